// file: include/iprl_regs.svh
// How it works
// - Eight-bit per-priority register, bit 7 zero
// - In priority mode each priority meters against its own code; port mode uses the priority 0 code
// - Priority 0-6 staged until priority 7 written
// - Code meaning depends on speed and unit
// - Codes 1-10 scale one meg, or 1.92k packets (19.2k at 1000)
// - Codes 11-100 scale per speed table
// - Packet column in packet mode, else bits
// - Packet mode bit selects packet counting
// - Scope bit selects port or priority limiting
`ifndef IPRL_REGS_SVH
`define IPRL_REGS_SVH

// ==================================================
// Address map, 0xN4xx with N the port 1..3
`define IPRL_PORT_MIN       4'h1
`define IPRL_PORT_MAX       4'h3
`define IPRL_OFS_CTRL       12'h403
`define IPRL_OFS_PRIO0      12'h410
`define IPRL_OFS_PRIO7      12'h417

// ==================================================
// Fields and reset values
`define IPRL_CTRL_PORT_BASED_BIT 6
`define IPRL_CTRL_PKT_MODE_BIT   5
`define IPRL_CTRL_RW_MASK        8'h7F
`define IPRL_CODE_MASK           8'h7F
`define IPRL_CODE_RESET          7'h00
`define IPRL_CTRL_RESET          8'h00

// ==================================================
// Rate table figures, packets/s and kbit/s
`define IPRL_PKT_STEP_LO    32'h0000_0780
`define IPRL_PKT_STEP_HI    32'h0000_4B00
`define IPRL_KBPS_1M        32'h0000_03E8
`define IPRL_KBPS_10M       32'h0000_2710
`define IPRL_CODE_LIN_MAX   7'h0A
`define IPRL_CODE_MID_MAX   7'h64
`define IPRL_CODE_TAB_MAX   7'h73

`endif

// file: include/iprl_pkg.sv
`default_nettype none
package iprl_pkg;
    typedef enum logic [1:0] {
        IPRL_SPD_10   = 2'b00,
        IPRL_SPD_100  = 2'b01,
        IPRL_SPD_1000 = 2'b10,
        IPRL_SPD_RSVD = 2'b11
    } iprl_speed_e;

    typedef logic [6:0]  iprl_code_t;
    typedef logic [55:0] iprl_port_codes_t;
    typedef logic [31:0] iprl_budget_t;
endpackage
`default_nettype wire

// file: hdl/iprl_code_mem.sv
`include "iprl_regs.svh"
`default_nettype none
module iprl_code_mem (
    input  wire logic        SYS_CLK_IN,    // Core clock
    input  wire logic        ARST_N_IN,     // Async reset, low
    input  wire logic        WR_EN_IN,      // Write strobe
    input  wire logic [1:0]  WR_ADDR_IN,    // Port index
    input  wire logic [55:0] WR_DATA_IN,    // Eight codes
    input  wire logic        RD_EN_IN,      // Read strobe
    input  wire logic [1:0]  RD_ADDR_IN,    // Port index
    output logic      [55:0] RD_DATA_OUT    // Registered read data
);
    logic [55:0] mem_reg [0:2];

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_word
            always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    mem_reg[g] <= 56'h0;
                else if (WR_EN_IN && WR_ADDR_IN == 2'(g))
                    mem_reg[g] <= WR_DATA_IN;
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            RD_DATA_OUT <= 56'h0;
        else if (RD_EN_IN)
            RD_DATA_OUT <= (RD_ADDR_IN < 2'h3) ? mem_reg[RD_ADDR_IN] : 56'h0;
    end
endmodule
`default_nettype wire

// file: hdl/iprl_bank.sv
`include "iprl_regs.svh"
`default_nettype none
module iprl_bank (
    input  wire logic        SYS_CLK_IN,        // Core clock, 125 MHz
    input  wire logic        ARST_N_IN,         // Async reset, low
    input  wire logic [15:0] REG_ADDR_IN,       // Management address
    input  wire logic        REG_WR_IN,         // Write strobe
    input  wire logic [7:0]  REG_WDATA_IN,      // Write data
    input  wire logic        REG_RD_IN,         // Read strobe
    output logic      [7:0]  REG_RDATA_OUT,     // Read data
    output logic             REG_RVALID_OUT,    // Read data valid pulse
    input  wire logic        QRY_VALID_IN,      // Budget query strobe
    input  wire logic [1:0]  QRY_PORT_IN,       // Port index 0..2
    input  wire logic [2:0]  QRY_PRIO_IN,       // Frame priority
    input  wire logic [1:0]  QRY_SPEED_IN,      // Link speed
    output logic             BUD_VALID_OUT,     // Budget valid pulse
    output logic      [31:0] BUD_RATE_OUT,      // Packets/s or kbit/s
    output logic             BUD_PKT_OUT,       // Rate is in packets
    output logic             BUD_PORT_BASED_OUT,// Whole-port limit
    output logic             BUD_DEFINED_OUT    // Table has an entry
);
    // ==================================================
    // Address decode
    logic [2:0]  wr_dec;
    logic [2:0]  rd_dec;
    logic [1:0]  wr_port;
    logic [1:0]  rd_port;

    // Returns {valid, is_ctrl, prio}, port separately
    function automatic logic [4:0] dec_addr(input logic [15:0] a);
        logic [4:0] r;
        r = 5'h00;
        if (a[15:12] >= `IPRL_PORT_MIN && a[15:12] <= `IPRL_PORT_MAX)
        begin
            if (a[11:0] == `IPRL_OFS_CTRL)
                r = 5'b11000;
            else if (a[11:0] >= `IPRL_OFS_PRIO0 && a[11:0] <= `IPRL_OFS_PRIO7)
                r = {2'b10, a[2:0]};
        end
        return r;
    endfunction

    logic [4:0] wr_d;
    logic [4:0] rd_d;
    assign wr_d    = dec_addr(REG_ADDR_IN);
    assign rd_d    = wr_d;
    assign wr_dec  = wr_d[2:0];
    assign rd_dec  = rd_d[2:0];
    assign wr_port = 2'(REG_ADDR_IN[13:12] - 2'h1);
    assign rd_port = wr_port;

    // ==================================================
    // Staging, control and shadow registers
    logic [6:0] stage_reg [0:2][0:6];
    logic [6:0] prio7_reg [0:2];
    logic [7:0] ctrl_reg  [0:2];
    logic       commit;
    logic [55:0] commit_word;

    assign commit = REG_WR_IN && wr_d[4] && !wr_d[3] && wr_dec == 3'h7;

    genvar p;
    genvar q;
    generate
        for (p = 0; p < 3; p++)
        begin : g_port
            for (q = 0; q < 7; q++)
            begin : g_prio
                always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
                begin
                    if (!ARST_N_IN)
                        stage_reg[p][q] <= `IPRL_CODE_RESET;
                    else if (REG_WR_IN && wr_d[4] && !wr_d[3] &&
                             wr_port == 2'(p) && wr_dec == 3'(q))
                        stage_reg[p][q] <= REG_WDATA_IN[6:0];
                end
            end
            always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    prio7_reg[p] <= `IPRL_CODE_RESET;
                else if (commit && wr_port == 2'(p))
                    prio7_reg[p] <= REG_WDATA_IN[6:0];
            end
            always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
            begin
                if (!ARST_N_IN)
                    ctrl_reg[p] <= `IPRL_CTRL_RESET;
                else if (REG_WR_IN && wr_d[4] && wr_d[3] && wr_port == 2'(p))
                    ctrl_reg[p] <= REG_WDATA_IN & `IPRL_CTRL_RW_MASK;
            end
        end
    endgenerate

    // Priority 7 code lands in the top slot of the committed word
    always_comb
    begin
        commit_word = {REG_WDATA_IN[6:0], 49'h0};
        for (int i = 0; i < 7; i++)
            commit_word[i*7 +: 7] = stage_reg[wr_port][i];
    end

    // ==================================================
    // Register read, one cycle latency
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            REG_RDATA_OUT <= 8'h00;
        else if (REG_RD_IN)
        begin
            if (!rd_d[4])
                REG_RDATA_OUT <= 8'h00;
            else if (rd_d[3])
                REG_RDATA_OUT <= ctrl_reg[rd_port];
            else if (rd_dec == 3'h7)
                REG_RDATA_OUT <= {1'b0, prio7_reg[rd_port]};
            else
                REG_RDATA_OUT <= {1'b0, stage_reg[rd_port][rd_dec]};
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            REG_RVALID_OUT <= 1'b0;
        else
            REG_RVALID_OUT <= REG_RD_IN;
    end

    // ==================================================
    // Active code store; commit writes all eight at once
    logic [55:0] active_word;

    iprl_code_mem u_mem (
        .SYS_CLK_IN  (SYS_CLK_IN),
        .ARST_N_IN   (ARST_N_IN),
        .WR_EN_IN    (commit),
        .WR_ADDR_IN  (wr_port),
        .WR_DATA_IN  (commit_word),
        .RD_EN_IN    (QRY_VALID_IN),
        .RD_ADDR_IN  (QRY_PORT_IN),
        .RD_DATA_OUT (active_word)
    );

    // ==================================================
    // Query pipeline stage 1
    logic        q1_valid_reg;
    logic [2:0]  q1_prio_reg;
    logic [1:0]  q1_speed_reg;
    logic        q1_pkt_reg;
    logic        q1_port_based_reg;

    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            q1_valid_reg      <= 1'b0;
            q1_prio_reg       <= 3'h0;
            q1_speed_reg      <= 2'h0;
            q1_pkt_reg        <= 1'b0;
            q1_port_based_reg <= 1'b0;
        end
        else
        begin
            q1_valid_reg <= QRY_VALID_IN && QRY_PORT_IN < 2'h3;
            if (QRY_VALID_IN && QRY_PORT_IN < 2'h3)
            begin
                q1_prio_reg       <= QRY_PRIO_IN;
                q1_speed_reg      <= QRY_SPEED_IN;
                q1_pkt_reg        <= ctrl_reg[QRY_PORT_IN][`IPRL_CTRL_PKT_MODE_BIT];
                q1_port_based_reg <= ctrl_reg[QRY_PORT_IN][`IPRL_CTRL_PORT_BASED_BIT];
            end
        end
    end

    // ==================================================
    // Rate decode
    // Returns {defined, rate}
    function automatic logic [32:0] decode_rate(input logic [6:0] c,
                                                input logic [1:0] s,
                                                input logic       pkt);
        logic [31:0] cw;
        logic [31:0] k;
        logic        hi;
        logic [32:0] r;
        cw = {25'h0, c};
        k  = cw - 32'd100;
        hi = (s == iprl_pkg::IPRL_SPD_1000);
        r  = {1'b1, 32'h0};
        if (s == iprl_pkg::IPRL_SPD_RSVD)
            r = 33'h0;
        else if (c == 7'h00)
        begin
            r[31:0] = pkt ? `IPRL_PKT_STEP_HI : `IPRL_KBPS_10M;
            if (s != iprl_pkg::IPRL_SPD_10)
                r[31:0] = 32'(r[31:0] * 32'd10);
            if (hi)
                r[31:0] = 32'(r[31:0] * 32'd10);
        end
        else if (c <= `IPRL_CODE_LIN_MAX)
            r[31:0] = pkt ? 32'(cw * (hi ? `IPRL_PKT_STEP_HI : `IPRL_PKT_STEP_LO))
                          : 32'(cw * `IPRL_KBPS_1M);
        else if (c <= `IPRL_CODE_MID_MAX)
        begin
            if (s == iprl_pkg::IPRL_SPD_10)
                r = pkt ? 33'h0 : {1'b1, `IPRL_KBPS_10M};
            else if (pkt)
                r[31:0] = 32'(cw * (hi ? `IPRL_PKT_STEP_HI : `IPRL_PKT_STEP_LO));
            else
                r[31:0] = 32'(cw * (hi ? `IPRL_KBPS_10M : `IPRL_KBPS_1M));
        end
        else if (c <= `IPRL_CODE_TAB_MAX)
        begin
            if (pkt)
            begin
                r[31:0] = (k == 32'd1) ? 32'd64 : 32'((k - 32'd1) * 32'd128);
                if (hi)
                    r[31:0] = 32'(r[31:0] * 32'd10);
            end
            else if (hi || (s == iprl_pkg::IPRL_SPD_100 && k <= 32'd3))
                r[31:0] = 32'(k * 32'd640);
            else
                r[31:0] = 32'(k * 32'd64);
        end
        else
            r = 33'h0; // Undefined codes give no budget
        return r;
    endfunction

    logic [6:0]  sel_code;
    logic [32:0] dec_res;

    // Port-wide limiting uses the priority 0 slot for all frames
    assign sel_code = q1_port_based_reg ? active_word[6:0]
                                        : active_word[q1_prio_reg*7 +: 7];
    assign dec_res  = decode_rate(sel_code, q1_speed_reg, q1_pkt_reg);

    // ==================================================
    // Query pipeline stage 2, registered outputs
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            BUD_VALID_OUT      <= 1'b0;
            BUD_RATE_OUT       <= 32'h0;
            BUD_PKT_OUT        <= 1'b0;
            BUD_PORT_BASED_OUT <= 1'b0;
            BUD_DEFINED_OUT    <= 1'b0;
        end
        else
        begin
            BUD_VALID_OUT <= q1_valid_reg;
            if (q1_valid_reg)
            begin
                BUD_RATE_OUT       <= dec_res[31:0];
                BUD_PKT_OUT        <= q1_pkt_reg;
                BUD_PORT_BASED_OUT <= q1_port_based_reg;
                BUD_DEFINED_OUT    <= dec_res[32];
            end
        end
    end
endmodule
`default_nettype wire

// file: verification/iprl_bank_properties.sv
`default_nettype none
module iprl_bank_properties (
    input wire logic        SYS_CLK_IN,     // Clock
    input wire logic        ARST_N_IN,      // Reset
    input wire logic        REG_RD_IN,      // Read
    input wire logic [7:0]  REG_RDATA_OUT,  // Data
    input wire logic        REG_RVALID_OUT, // Valid
    input wire logic        QRY_VALID_IN,   // Query
    input wire logic [1:0]  QRY_PORT_IN,    // Port
    input wire logic [1:0]  QRY_SPEED_IN,   // Speed
    input wire logic        BUD_VALID_OUT,  // Valid
    input wire logic [31:0] BUD_RATE_OUT,   // Rate
    input wire logic        BUD_DEFINED_OUT // Defined
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    // ==================================
    // Checks
    sequence s_qry;
        QRY_VALID_IN && QRY_PORT_IN != 2'h3;
    endsequence
    a_read_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT && !REG_RDATA_OUT[7])
        else $error("read answer wrong");
    a_rvalid_cause: assert property (REG_RVALID_OUT |-> $past(REG_RD_IN))
        else $error("read valid without read");
    a_rdata_hold: assert property (!REG_RVALID_OUT |-> $stable(REG_RDATA_OUT))
        else $error("read data moved");
    a_budget_lat: assert property (s_qry |-> ##2 BUD_VALID_OUT)
        else $error("budget late");
    a_budget_cause: assert property (BUD_VALID_OUT |-> $past(QRY_VALID_IN, 2)
        && $past(QRY_PORT_IN, 2) != 2'h3)
        else $error("budget without query");
    a_rate_hold: assert property (!BUD_VALID_OUT |-> $stable(BUD_RATE_OUT))
        else $error("budget moved");
    a_undef_zero: assert property (BUD_VALID_OUT && !BUD_DEFINED_OUT |-> BUD_RATE_OUT == 0)
        else $error("undefined rate not zero");
    a_rsvd_speed: assert property (s_qry ##0 QRY_SPEED_IN == 2'h3 |-> ##2 !BUD_DEFINED_OUT)
        else $error("reserved speed defined");
endmodule

bind iprl_bank iprl_bank_properties iprl_bank_properties_i (
    .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
    .QRY_VALID_IN(QRY_VALID_IN), .QRY_PORT_IN(QRY_PORT_IN), .QRY_SPEED_IN(QRY_SPEED_IN),
    .BUD_VALID_OUT(BUD_VALID_OUT), .BUD_RATE_OUT(BUD_RATE_OUT),
    .BUD_DEFINED_OUT(BUD_DEFINED_OUT)
);
`default_nettype wire

// file: verification/iprl_host_model.sv
`default_nettype none
module iprl_host_model (
    input  wire logic        clk_in,   // Clock
    output logic      [15:0] addr_out, // Address
    output logic             wr_out,   // Write
    output logic      [7:0]  wd_out,   // Data
    output logic             rd_out    // Read
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {addr_out, wr_out, wd_out, rd_out} = '0;
    end
    // ==================================
    // Released address and data inverted, both strobes dropped low
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {addr_out, wd_out, wr_out, rd_out} = {a, d, w, !w};
        @(negedge clk_in);
        {addr_out, wd_out, wr_out, rd_out} = {~a, ~d, 2'b00};
    endtask
    task automatic commit(input logic [3:0] n, input logic [6:0] c [8]);
        for (int i = 0; i < 8; i++)
            access(1'b1, {n, 12'h410 + 12'(i)}, {1'b0, c[i]});
    endtask
endmodule
`default_nettype wire

// file: verification/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, wr, rd, rv, qv, bv, bpkt, bpb, bdef;
    logic [15:0] addr;
    logic [7:0]  wd, rdata;
    logic [1:0]  qport, qspd;
    logic [2:0]  qprio;
    logic [31:0] brate;
    int          err_total, total_checks;

    iprl_bank iprl_bank_i (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr),
        .REG_WR_IN(wr), .REG_WDATA_IN(wd), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .REG_RVALID_OUT(rv), .QRY_VALID_IN(qv), .QRY_PORT_IN(qport), .QRY_PRIO_IN(qprio),
        .QRY_SPEED_IN(qspd), .BUD_VALID_OUT(bv), .BUD_RATE_OUT(brate), .BUD_PKT_OUT(bpkt),
        .BUD_PORT_BASED_OUT(bpb), .BUD_DEFINED_OUT(bdef));
    iprl_host_model host_i (.clk_in(clk), .addr_out(addr), .wr_out(wr), .wd_out(wd),
        .rd_out(rd));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==================================
    // Helpers
    task automatic summarize(input bit hung);
        err_total += hung;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        host_i.access(1'b0, a, 8'h00);
        if (rv !== 1'b1)
            summarize(1'b1);
        else
            chk({24'h0, rdata}, {24'h0, e});
    endtask
    task automatic qry(input logic [1:0] p, input logic [2:0] pr, input logic [1:0] s,
                       input logic [32:0] e, input logic ep, input logic eb);
        int n;
        {qv, qport, qprio, qspd} = {1'b1, p, pr, s};
        @(negedge clk);
        qv = 1'b0;
        for (n = 0; n < 4 && bv !== 1'b1; n++)
            @(negedge clk);
        if (n == 4)
            summarize(1'b1);
        else
        begin
            chk(brate, e[31:0]);
            chk({31'h0, bdef}, {31'h0, e[32]});
            chk({31'h0, bpkt}, {31'h0, ep});
            chk({31'h0, bpb}, {31'h0, eb});
        end
    endtask
    // Defined flag on top of the expected rate
    function automatic logic [32:0] er(input int c, input int s, input bit pk);
        int sc;
        int k;
        int r;
        sc = (s == 2) ? 10 : 1;
        k = c - 100;
        if (s == 3 || c > 115 || (s == 0 && pk && c > 10 && c < 101))
            return 33'h0;
        if (c == 0)
            r = (pk ? 19200 : 10000) * (s == 0 ? 1 : s == 1 ? 10 : 100);
        else if (c < 11)
            r = pk ? c * 1920 * sc : c * 1000;
        else if (c < 101)
            r = (s == 0) ? 10000 : c * (pk ? 1920 : 1000) * sc;
        else if (pk)
            r = (k == 1 ? 64 : (k - 1) * 128) * sc;
        else
            r = (s == 2 || (s == 1 && k < 4)) ? 640 * k : 64 * k;
        return {1'b1, 32'(r)};
    endfunction

    // ==================================
    // Scenarios
    task automatic sc_reset_values();
        for (int n = 1; n < 4; n++)
            for (int p = 0; p < 9; p++)
                rdc({4'(n), p == 8 ? 12'h403 : 12'h410 + 12'(p)}, 8'h00);
    endtask
    task automatic sc_staging();
        host_i.access(1'b1, 16'h1410, 8'h85);
        rdc(16'h1410, 8'h05);
        qry(2'd0, 3'd0, 2'd2, er(0, 2, 0), 1'b0, 1'b0);
        host_i.access(1'b1, 16'h1417, 8'h02);
        qry(2'd0, 3'd0, 2'd2, er(5, 2, 0), 1'b0, 1'b0);
        qry(2'd0, 3'd7, 2'd2, er(2, 2, 0), 1'b0, 1'b0);
    endtask
    task automatic sc_decode_sweep();
        int cs [16] = '{0, 1, 10, 11, 55, 100, 101, 102, 103, 104, 109, 113, 114, 115, 116, 127};
        logic [6:0] cv [8];
        for (int r = 0; r < 2; r++)
        begin
            for (int i = 0; i < 8; i++)
                cv[i] = 7'(cs[r * 8 + i]);
            host_i.commit(4'h2, cv);
            for (int pk = 0; pk < 2; pk++)
            begin
                host_i.access(1'b1, 16'h2403, pk ? 8'h20 : 8'h00);
                for (int s = 0; s < 16; s++)
                    qry(2'd1, 3'(s), 2'(s >> 3), er(cs[r * 8 + s % 8], s >> 3, pk[0]),
                        pk[0], 1'b0);
                for (int s = 0; s < 16; s++)
                    qry(2'd1, 3'(s), 2'(2 + (s >> 3)), er(cs[r * 8 + s % 8], 2 + (s >> 3),
                        pk[0]), pk[0], 1'b0);
            end
        end
    endtask
    task automatic sc_port_based();
        logic [6:0] cv [8];
        host_i.access(1'b1, 16'h3403, 8'hE0);
        rdc(16'h3403, 8'h60);
        cv = '{7'd7, 7'd50, 7'd1, 7'd1, 7'd1, 7'd1, 7'd1, 7'd3};
        host_i.commit(4'h3, cv);
        qry(2'd2, 3'd5, 2'd1, er(7, 1, 1), 1'b1, 1'b1);
    endtask
    task automatic sc_unmapped();
        host_i.access(1'b1, 16'h4410, 8'h11);
        rdc(16'h4410, 8'h00);
        rdc(16'h3420, 8'h00);
        {qv, qport} = 3'b111;
        @(negedge clk);
        qv = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    initial
    begin
        {err_total, total_checks, rst_n, qv, qport, qprio, qspd} = '0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        sc_reset_values();
        sc_staging();
        sc_decode_sweep();
        sc_port_based();
        sc_unmapped();
        summarize(1'b0);
    end
endmodule
`default_nettype wire
